// File: logic/scdi_map.svh
// Purpose: constants for the step/direction command input block
// Assumes: 50 MHz clock, all pins already synchronous to it
// Notes:   times are kept in their own unit, cycle counts derive from them
`ifndef SCDI_MAP_SVH
`define SCDI_MAP_SVH

`define SCDI_POS_W        32
`define SCDI_CUR_W        16
`define SCDI_CLK_MHZ      50
`define SCDI_STEP_MIN_NS  2500
`define SCDI_DIR_SETUP_NS 5000
`define SCDI_STEP_MAX_KHZ 200
`define SCDI_TICK_US      1000
`define SCDI_TICK_CYCLES  (`SCDI_TICK_US * `SCDI_CLK_MHZ)
`define SCDI_FLASH_ON_MS  12'h12C
`define SCDI_FLASH_OFF_MS 12'h12C
`define SCDI_DARK_MS      12'h7D0
`define SCDI_FOLLOW_LIMIT 32'h00000FA0
`define SCDI_KP_SHIFT     2
`define SCDI_KV_SHIFT     1
`define SCDI_CUR_MAX      16'h7FFF
`define SCDI_CUR_MIN      16'h8001

`endif

// File: logic/scdi_pkg.sv
// Purpose: shared types for the step/direction command input block
// Assumes: constants come from scdi_map.svh
// Notes:   fault codes double as red flash counts
package scdi_pkg;

  typedef enum logic [1:0] {
    SCDI_FLT_NONE,
    SCDI_FLT_OVER_CURRENT,
    SCDI_FLT_OVER_VOLTAGE,
    SCDI_FLT_FOLLOW
  } scdi_fault_t;

  typedef enum logic [1:0] {
    SCDI_BL_IDLE,
    SCDI_BL_ON,
    SCDI_BL_OFF,
    SCDI_BL_DARK
  } scdi_blink_st_t;

endpackage

// File: logic/scdi_blink_if.sv
// Purpose: carries fault code and tick between core and lamp sequencer
// Assumes: single clock domain
// Notes:   lamp level returns from the sequencer flop
`timescale 1ns/1ps
interface scdi_blink_if;
  import scdi_pkg::*;
  scdi_fault_t code;
  logic        tick;
  logic        led;
  modport src   (output code, output tick, input led);
  modport blink (input code, input tick, output led);
endinterface

// File: logic/scdi_blink.sv
// Purpose: red lamp flash sequencer, one flash per fault code step
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   pattern always completes its dark gap before re-reading code
`timescale 1ns/1ps
`include "scdi_map.svh"
module scdi_blink
  import scdi_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // sequencer side
  scdi_blink_if.blink bl
);

  scdi_blink_st_t st_r;
  logic [11:0]    ms_r;
  logic [1:0]     left_r;

  function automatic logic [1:0] flash_count(input scdi_fault_t c);
    case (c)
      SCDI_FLT_OVER_CURRENT: flash_count = 2'h1;
      SCDI_FLT_OVER_VOLTAGE: flash_count = 2'h2;
      SCDI_FLT_FOLLOW:       flash_count = 2'h3;
      default:               flash_count = 2'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // flash sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r   <= SCDI_BL_IDLE;
      ms_r   <= 12'h000;
      left_r <= 2'h0;
      bl.led <= 1'b0;
    end else begin
      case (st_r)
        SCDI_BL_IDLE: begin
          bl.led <= 1'b0;
          if (flash_count(bl.code) != 2'h0) begin
            st_r   <= SCDI_BL_ON;
            left_r <= flash_count(bl.code);
            ms_r   <= 12'h000;
            bl.led <= 1'b1;
          end
        end
        SCDI_BL_ON: begin
          if (bl.tick) begin
            if (ms_r == `SCDI_FLASH_ON_MS - 12'h001) begin
              ms_r   <= 12'h000;
              bl.led <= 1'b0;
              left_r <= left_r - 2'h1;
              st_r   <= (left_r == 2'h1) ? SCDI_BL_DARK : SCDI_BL_OFF;
            end else begin
              ms_r <= ms_r + 12'h001;
            end
          end
        end
        SCDI_BL_OFF: begin
          if (bl.tick) begin
            if (ms_r == `SCDI_FLASH_OFF_MS - 12'h001) begin
              ms_r   <= 12'h000;
              bl.led <= 1'b1;
              st_r   <= SCDI_BL_ON;
            end else begin
              ms_r <= ms_r + 12'h001;
            end
          end
        end
        SCDI_BL_DARK: begin
          // fixed gap marks where one repeat ends
          if (bl.tick) begin
            if (ms_r == `SCDI_DARK_MS - 12'h001) begin
              ms_r <= 12'h000;
              st_r <= SCDI_BL_IDLE;
            end else begin
              ms_r <= ms_r + 12'h001;
            end
          end
        end
        default: begin
          st_r   <= SCDI_BL_IDLE;
          bl.led <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  blink_dark_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_r == SCDI_BL_DARK || st_r == SCDI_BL_OFF) |-> !bl.led)
    else $error("red lamp lit during a gap");
  blink_start_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_r == SCDI_BL_IDLE && bl.code != SCDI_FLT_NONE) |=> bl.led)
    else $error("red lamp did not start flashing on fault");

endmodule

// File: logic/scdi_step_dir_top.sv
// Purpose: step/direction command decode, position loops, status lamps
// Assumes: host pins synchronous to clk_in; host keeps pulse timing
// Notes:   fault latches until fault_clear_in or reset
`timescale 1ns/1ps
`include "scdi_map.svh"
module scdi_step_dir_top
  import scdi_pkg::*;
#(
  parameter int TICK_CYCLES = `SCDI_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  // host command pins
  input  wire logic                          step_pulse_input_in,
  input  wire logic                          direction_in,
  input  wire logic                          drive_enable_input_in,
  // configuration
  input  wire logic                          cfg_double_pulse_in,
  input  wire logic                          cfg_falling_edge_in,
  input  wire logic                          cfg_enable_low_in,
  input  wire logic                          direction_invert_switch_in,
  input  wire logic                          cfg_fault_invert_in,
  // encoder and protection
  input  wire logic                          enc_a_in,
  input  wire logic                          enc_b_in,
  input  wire logic                          over_voltage_in,
  input  wire logic                          over_current_in,
  input  wire logic                          fault_clear_in,
  // position and loop outputs
  output logic signed [`SCDI_POS_W-1:0]      cmd_pos_out,
  output logic signed [`SCDI_POS_W-1:0]      enc_pos_out,
  output logic signed [`SCDI_CUR_W-1:0]      current_cmd_out,
  output logic                               drive_enabled_out,
  // status
  output logic                               in_position_out,
  output logic                               fault_output_out,
  output logic                               power_led_out,
  output logic                               error_led_out
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  logic                          step_prev_r;
  logic                          dir_prev_r;
  logic                          enc_a_r;
  logic                          enc_b_r;
  logic signed [`SCDI_POS_W-1:0] enc_last_r;
  logic signed [`SCDI_POS_W-1:0] pos_err_r;
  logic signed [`SCDI_CUR_W-1:0] vel_meas_r;
  logic [TICK_W-1:0]             tick_cnt_r;
  logic                          tick_r;
  logic                          fault_r;
  scdi_fault_t                   code_r;
  logic                          enabled;
  logic                          dir_positive;
  logic                          step_hit;
  logic                          ccw_hit;
  logic [1:0]                    cmd_delta;
  logic [1:0]                    enc_delta;
  logic signed [`SCDI_POS_W-1:0] vel_cmd;
  logic signed [`SCDI_POS_W-1:0] cur_raw;
  logic signed [`SCDI_POS_W-1:0] vel_wide;
  logic                          follow_err;

  scdi_blink_if bl_if ();

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // true on the configured edge of a pin against its previous sample
  function automatic logic edge_hit(input logic now, input logic prev,
                                    input logic falling);
    edge_hit = falling ? (prev & ~now) : (now & ~prev);
  endfunction

  // clamp to the current command range
  function automatic logic signed [`SCDI_CUR_W-1:0] sat_cur(
      input logic signed [`SCDI_POS_W-1:0] v);
    if (v > $signed({{(`SCDI_POS_W-`SCDI_CUR_W){1'b0}}, `SCDI_CUR_MAX}))
      sat_cur = `SCDI_CUR_MAX;
    else if (v < $signed({{(`SCDI_POS_W-`SCDI_CUR_W){1'b1}}, `SCDI_CUR_MIN}))
      sat_cur = `SCDI_CUR_MIN;
    else
      sat_cur = v[`SCDI_CUR_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  always_comb begin
    enabled      = drive_enable_input_in ^ cfg_enable_low_in;
    // switch on: direction high moves positive; off reverses
    dir_positive = direction_in ^ ~direction_invert_switch_in;
    step_hit     = edge_hit(step_pulse_input_in, step_prev_r,
                            cfg_falling_edge_in);
    ccw_hit      = cfg_double_pulse_in &
                   edge_hit(direction_in, dir_prev_r, cfg_falling_edge_in);
    cmd_delta    = 2'h0;
    if (!enabled) begin
      cmd_delta = 2'h0;
    end else if (!cfg_double_pulse_in) begin
      if (step_hit) begin
        cmd_delta = dir_positive ? 2'h1 : 2'h3;
      end
    end else begin
      // both trains at once cancel out
      if (step_hit && !ccw_hit) begin
        cmd_delta = direction_invert_switch_in ? 2'h1 : 2'h3;
      end else if (ccw_hit && !step_hit) begin
        cmd_delta = direction_invert_switch_in ? 2'h3 : 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      step_prev_r <= 1'b0;
      dir_prev_r  <= 1'b0;
      cmd_pos_out <= '0;
    end else begin
      step_prev_r <= step_pulse_input_in;
      dir_prev_r  <= direction_in;
      cmd_pos_out <= cmd_pos_out
                     + {{(`SCDI_POS_W-2){cmd_delta[1]}}, cmd_delta};
    end
  end

  // ---------------------------------------------------------------
  // encoder quadrature count
  // ---------------------------------------------------------------
  always_comb begin
    case ({enc_a_r, enc_b_r, enc_a_in, enc_b_in})
      4'h1, 4'h7, 4'hE, 4'h8: enc_delta = 2'h1;
      4'h2, 4'hB, 4'hD, 4'h4: enc_delta = 2'h3;
      default:                enc_delta = 2'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enc_a_r     <= 1'b0;
      enc_b_r     <= 1'b0;
      enc_pos_out <= '0;
    end else begin
      enc_a_r     <= enc_a_in;
      enc_b_r     <= enc_b_in;
      enc_pos_out <= enc_pos_out
                     + {{(`SCDI_POS_W-2){enc_delta[1]}}, enc_delta};
    end
  end

  // ---------------------------------------------------------------
  // position, velocity and current loops
  // ---------------------------------------------------------------
  always_comb begin
    vel_cmd = pos_err_r >>> `SCDI_KP_SHIFT;
    // kept signed so the shift stays arithmetic for negative errors
    vel_wide = $signed({{(`SCDI_POS_W-`SCDI_CUR_W){
                           vel_meas_r[`SCDI_CUR_W-1]}}, vel_meas_r});
    cur_raw  = (vel_cmd - vel_wide) >>> `SCDI_KV_SHIFT;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enc_last_r      <= '0;
      pos_err_r       <= '0;
      vel_meas_r      <= '0;
      current_cmd_out <= '0;
    end else begin
      enc_last_r <= enc_pos_out;
      pos_err_r  <= cmd_pos_out - enc_pos_out;
      vel_meas_r <= sat_cur(enc_pos_out - enc_last_r);
      // no torque while disabled or tripped
      if (!enabled || fault_r) begin
        current_cmd_out <= '0;
      end else begin
        current_cmd_out <= sat_cur(cur_raw);
      end
    end
  end

  // ---------------------------------------------------------------
  // status and protection
  // ---------------------------------------------------------------
  assign follow_err = (pos_err_r > $signed(`SCDI_FOLLOW_LIMIT)) ||
                      (pos_err_r < -$signed(`SCDI_FOLLOW_LIMIT));

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      in_position_out   <= 1'b0;
      drive_enabled_out <= 1'b0;
      power_led_out     <= 1'b0;
    end else begin
      in_position_out   <= (cmd_pos_out == enc_pos_out);
      drive_enabled_out <= enabled;
      power_led_out     <= 1'b1;
    end
  end

  // new trips win over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fault_r          <= 1'b0;
      code_r           <= SCDI_FLT_NONE;
      fault_output_out <= 1'b0;
    end else begin
      if (over_current_in) begin
        fault_r <= 1'b1;
        code_r  <= SCDI_FLT_OVER_CURRENT;
      end else if (over_voltage_in) begin
        fault_r <= 1'b1;
        code_r  <= SCDI_FLT_OVER_VOLTAGE;
      end else if (follow_err) begin
        fault_r <= 1'b1;
        code_r  <= SCDI_FLT_FOLLOW;
      end else if (fault_clear_in) begin
        fault_r <= 1'b0;
        code_r  <= SCDI_FLT_NONE;
      end
      // high means the output transistor conducts
      fault_output_out <= ~fault_r ^ cfg_fault_invert_in;
    end
  end

  // ---------------------------------------------------------------
  // lamp tick and sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  assign bl_if.code    = code_r;
  assign bl_if.tick    = tick_r;
  assign error_led_out = bl_if.led;

  scdi_blink u_blink (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .bl         (bl_if.blink)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  single_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (enabled && !cfg_double_pulse_in && step_hit)
    |=> cmd_pos_out - $past(cmd_pos_out) ==
        ($past(dir_positive) ? 1 : -1))
    else $error("single-pulse step not counted in its direction");
  no_edge_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!cfg_double_pulse_in && step_pulse_input_in == step_prev_r)
    |=> $stable(cmd_pos_out))
    else $error("command moved without a step edge");
  double_cw_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (enabled && cfg_double_pulse_in && step_hit && !ccw_hit &&
     direction_invert_switch_in)
    |=> cmd_pos_out == $past(cmd_pos_out) + 1)
    else $error("clockwise pulse not counted up");
  double_ccw_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (enabled && cfg_double_pulse_in && ccw_hit && !step_hit &&
     direction_invert_switch_in)
    |=> cmd_pos_out == $past(cmd_pos_out) - 1)
    else $error("counter-clockwise pulse not counted down");
  disabled_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (drive_enable_input_in == cfg_enable_low_in) [*2]
    |-> $stable(cmd_pos_out) && !drive_enabled_out)
    else $error("command moved while drive disabled");
  invert_dir_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (enabled && !cfg_double_pulse_in && step_hit && direction_in &&
     !direction_invert_switch_in)
    |=> cmd_pos_out == $past(cmd_pos_out) - 1)
    else $error("switch off did not reverse direction");
  power_lamp_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $past(!sys_rst_in) |-> power_led_out)
    else $error("power lamp dark after reset");
  in_pos_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_position_out |-> $past(cmd_pos_out) == $past(enc_pos_out))
    else $error("in-position without matching positions");
  fault_out_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (over_voltage_in || over_current_in)
    |=> ##1 fault_output_out == $past(cfg_fault_invert_in))
    else $error("fault output did not open on a trip");

endmodule

// File: testbench/scdi_host_model.sv
// Purpose: host motion controller driving the step and direction pins
// Assumes: pins change only at the falling edge of clk_in
// Notes:   step idles low outside pulses; dir holds the last level set_dir or drive gives it
`timescale 1ns/1ps
module scdi_host_model (
  // clock
  input  wire logic clk_in,
  // command pins
  output logic      step_out,
  output logic      dir_out
);
  // ----------------------------------------
  // pulse timing
  // ----------------------------------------
  // 130 cycles is 2.6 us; a full pulse of 260 cycles stays under 200 kHz
  localparam int PULSE_CYC = 130;
  localparam int SETUP_CYC = 255;

  initial begin
    step_out = 1'b0;
    dir_out  = 1'b0;
  end

  // direction level settles well ahead of the next step
  task automatic set_dir(input logic v);
    @(negedge clk_in);
    dir_out <= v;
    repeat (SETUP_CYC) @(negedge clk_in);
  endtask

  // one half of a pulse on either line, held for its full width
  task automatic drive(input logic on_dir, input logic v);
    @(negedge clk_in);
    if (on_dir) begin
      dir_out <= v;
    end else begin
      step_out <= v;
    end
    repeat (PULSE_CYC) @(negedge clk_in);
  endtask
endmodule

// File: testbench/testbench.sv
// Purpose: self-checking bench for the step/direction command input
// Assumes: lamp tick shortened to 10 cycles
// Notes:   encoder moves only in its own scenario
`timescale 1ns/1ps
`include "scdi_map.svh"
module testbench
  import scdi_pkg::*;
;
  logic clk_in, sys_rst_in, en, dbl, fall, enlow, sw, finv;
  logic ea, eb, ov, oc, clr, stp, dir;
  logic signed [`SCDI_POS_W-1:0] cmd, enc;
  logic signed [`SCDI_CUR_W-1:0] cur;
  logic den, inpos, fo, pled, eled;
  int fails, n_tests;

  scdi_host_model host (.clk_in(clk_in), .step_out(stp), .dir_out(dir));

  scdi_step_dir_top #(.TICK_CYCLES(10)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .step_pulse_input_in(stp), .direction_in(dir),
    .drive_enable_input_in(en), .cfg_double_pulse_in(dbl),
    .cfg_falling_edge_in(fall), .cfg_enable_low_in(enlow),
    .direction_invert_switch_in(sw), .cfg_fault_invert_in(finv),
    .enc_a_in(ea), .enc_b_in(eb), .over_voltage_in(ov),
    .over_current_in(oc), .fault_clear_in(clr),
    .cmd_pos_out(cmd), .enc_pos_out(enc), .current_cmd_out(cur),
    .drive_enabled_out(den), .in_position_out(inpos),
    .fault_output_out(fo), .power_led_out(pled), .error_led_out(eled));

  // ----------------------------------------
  // clock, checks and closing
  // ----------------------------------------
  initial clk_in = 1'b0;
  always #10 clk_in = ~clk_in;

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t value %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic pulse(input logic on_dir);
    host.drive(on_dir, 1'b1);
    host.drive(on_dir, 1'b0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_single;
    host.set_dir(1'b1);
    pulse(1'b0);
    pulse(1'b0);
    chk_val(cmd, 32'h00000002);
    chk_bit(inpos, 1'b0);
    host.set_dir(1'b0);
    pulse(1'b0);
    pulse(1'b0);
    chk_val(cmd, 32'h00000000);
    chk_bit(inpos, 1'b1);
  endtask

  task automatic t_invert_and_edge;
    @(negedge clk_in) sw = 1'b0;
    host.set_dir(1'b1);
    pulse(1'b0);
    chk_val(cmd, 32'hFFFFFFFF);
    @(negedge clk_in) sw = 1'b1;
    @(negedge clk_in) fall = 1'b1;
    host.drive(1'b0, 1'b1);
    chk_val(cmd, 32'hFFFFFFFF);
    host.drive(1'b0, 1'b0);
    chk_val(cmd, 32'h00000000);
    @(negedge clk_in) fall = 1'b0;
    host.set_dir(1'b0);
  endtask

  task automatic t_double;
    @(negedge clk_in) dbl = 1'b1;
    pulse(1'b0);
    chk_val(cmd, 32'h00000001);
    pulse(1'b1);
    pulse(1'b1);
    chk_val(cmd, 32'hFFFFFFFF);
    @(negedge clk_in) sw = 1'b0;
    pulse(1'b0);
    chk_val(cmd, 32'hFFFFFFFE);
    pulse(1'b1);
    chk_val(cmd, 32'hFFFFFFFF);
    @(negedge clk_in) sw = 1'b1;
    @(negedge clk_in) dbl = 1'b0;
  endtask

  task automatic t_enable;
    @(negedge clk_in) en = 1'b0;
    repeat (3) @(negedge clk_in);
    chk_bit(den, 1'b0);
    chk_val({16'h0000, cur}, 32'h00000000);
    pulse(1'b0);
    chk_val(cmd, 32'hFFFFFFFF);
    @(negedge clk_in) enlow = 1'b1;
    repeat (3) @(negedge clk_in);
    chk_bit(den, 1'b1);
    pulse(1'b0);
    chk_val(cmd, 32'hFFFFFFFE);
    @(negedge clk_in) en = 1'b1;
    repeat (3) @(negedge clk_in);
    chk_bit(den, 1'b0);
    @(negedge clk_in) enlow = 1'b0;
    repeat (3) @(negedge clk_in);
    chk_bit(den, 1'b1);
    // error of -2 counts, shifted by 2 then 1, gives -1
    chk_val({16'h0000, cur}, 32'h0000FFFF);
  endtask

  // two quadrature steps with A leading bring the encoder to -2
  task automatic t_encoder;
    chk_bit(inpos, 1'b0);
    @(negedge clk_in) ea = 1'b1;
    @(negedge clk_in) eb = 1'b1;
    repeat (4) @(negedge clk_in);
    chk_val(enc, 32'hFFFFFFFE);
    chk_bit(inpos, 1'b1);
    chk_val({16'h0000, cur}, 32'h00000000);
  endtask

  // counts red flashes over one repeat period, lamp tick is 10 cycles
  task automatic flashes(input int n);
    int   k;
    int   cnt;
    logic prev;
    cnt = 0;
    for (k = 0; k < 3000 && eled !== 1'b1; k++) @(negedge clk_in);
    prev = 1'b0;
    repeat (n * 6000 + 16000) begin
      if (eled === 1'b1 && prev === 1'b0) cnt++;
      prev = eled;
      @(negedge clk_in);
    end
    chk_val(cnt, n);
  endtask

  task automatic t_fault;
    @(negedge clk_in) oc = 1'b1;
    repeat (2) @(negedge clk_in);
    chk_bit(fo, 1'b0);
    chk_val({16'h0000, cur}, 32'h00000000);
    @(negedge clk_in) clr = 1'b1;
    @(negedge clk_in) clr = 1'b0;
    @(negedge clk_in) finv = 1'b1;
    repeat (2) @(negedge clk_in);
    chk_bit(fo, 1'b1);
    @(negedge clk_in) finv = 1'b0;
    oc = 1'b0;
    flashes(1);
    @(negedge clk_in) clr = 1'b1;
    @(negedge clk_in) clr = 1'b0;
    repeat (3) @(negedge clk_in);
    chk_bit(fo, 1'b1);
    repeat (1500) @(negedge clk_in);
    @(negedge clk_in) ov = 1'b1;
    repeat (2) @(negedge clk_in);
    chk_bit(fo, 1'b0);
    @(negedge clk_in) ov = 1'b0;
    flashes(2);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    fails = 0;
    n_tests = 0;
    sys_rst_in = 1'b1;
    {en, sw} = 2'h3;
    {dbl, fall, enlow, finv, ea, eb, ov, oc, clr} = 9'h000;
    repeat (16) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk_bit(pled, 1'b1);
    chk_bit(fo, 1'b1);
    chk_bit(den, 1'b1);
    chk_bit(inpos, 1'b1);
    t_single;
    t_invert_and_edge;
    t_double;
    t_enable;
    t_encoder;
    t_fault;
    test_done;
  end

  // whole run is near 56k cycles; limit of 95k cycles sits about 39k above it
  initial begin
    repeat (95000) @(posedge clk_in);
    fails++;
    test_done;
  end
endmodule
